// file: dv/lls_assertions.sv
`timescale 1ns/100ps
`include "lls_defs.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module lls_chk #(
  parameter LAMPS = 64,
  parameter AW = 6
) (
  input wire clk_in,
  input wire resetn_in,
  input wire download_in,
  input wire supply_return_in,
  input wire [7:0] min_level_in,
  input wire [7:0] max_level_in,
  input wire burn_in_in,
  input wire [1:0] switch_rpt_mode_in,
  input wire [1:0] level_rpt_mode_in,
  input wire sel_slave_valid_in,
  input wire chan_slave_valid_in,
  input wire chan_slave_value_in,
  input wire rpt_ready_in,
  input wire rpt_valid_out,
  input wire rpt_is_level_out,
  input wire [AW-1:0] rpt_addr_out,
  input wire [7:0] rpt_data_out,
  input wire [AW-1:0] drive_addr_out,
  input wire [7:0] drive_level_out,
  input wire drive_valid_out,
  input wire [LAMPS-1:0] slave_out
);
  reg [16:0] lim_r;
  reg [9:0] age_r;
  reg [AW-1:0] last_r;
  reg seen_r;
  wire [16:0] lim = {min_level_in, max_level_in, burn_in_in};
  wire [7:0] lo = (min_level_in > max_level_in) ? max_level_in : min_level_in;
  wire [7:0] hi = (max_level_in < min_level_in) ? min_level_in : max_level_in;
  wire quiet = !download_in && !supply_return_in;
  always @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      lim_r <= 17'h00000;
      age_r <= 10'h000;
      last_r <= {AW{1'b0}};
      seen_r <= 1'b0;
    end
    else
    begin
      lim_r <= lim;
      age_r <= (lim != lim_r) ? 10'h000 : age_r + {9'h000, ~&age_r};
      last_r <= drive_valid_out ? drive_addr_out : last_r;
      seen_r <= quiet && (seen_r || drive_valid_out);
    end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_clear;
    (download_in || supply_return_in) [*2];
  endsequence
  a_rpt_hold: assert property (rpt_valid_out && !rpt_ready_in |=> rpt_valid_out
    && $stable({rpt_is_level_out, rpt_addr_out, rpt_data_out}))
    else $error("report changed before ready");
  a_no_sw_rpt: assert property (rpt_valid_out && !rpt_is_level_out |->
    switch_rpt_mode_in != `LLS_RPT_NONE) else $error("switch report while off");
  a_no_lvl_rpt: assert property (rpt_valid_out && rpt_is_level_out |->
    level_rpt_mode_in != `LLS_RPT_NONE) else $error("level report while off");
  a_level_limits: assert property (drive_valid_out && !burn_in_in && &age_r |->
    drive_level_out == 8'h00 || (drive_level_out >= lo && drive_level_out <= hi))
    else $error("level outside limits");
  a_burn_levels: assert property (drive_valid_out && burn_in_in && &age_r |->
    drive_level_out == 8'h00 || drive_level_out == 8'hFF) else $error("burn-in level");
  a_clear_slave: assert property (s_clear |-> ##[1:4] slave_out == '0)
    else $error("slave bits not cleared");
  a_chan_all: assert property (chan_slave_valid_in && chan_slave_value_in && quiet
    && !sel_slave_valid_in |=> &slave_out) else $error("channel slave not set");
  a_sel_one: assert property (sel_slave_valid_in && !chan_slave_valid_in && quiet |=>
    $countones(slave_out ^ $past(slave_out)) <= 1) else $error("several slave bits moved");
  a_scan_order: assert property (drive_valid_out && seen_r |->
    drive_addr_out == last_r + 1'b1) else $error("poll order broken");
endmodule // lls_chk

bind lls_lamp_ctrl lls_chk #(.LAMPS(LAMPS), .AW(AW)) u_chk (.clk_in(clk_in),
  .resetn_in(resetn_in), .download_in(download_in), .supply_return_in(supply_return_in),
  .min_level_in(min_level_in), .max_level_in(max_level_in), .burn_in_in(burn_in_in),
  .switch_rpt_mode_in(switch_rpt_mode_in), .level_rpt_mode_in(level_rpt_mode_in),
  .sel_slave_valid_in(sel_slave_valid_in), .chan_slave_valid_in(chan_slave_valid_in),
  .chan_slave_value_in(chan_slave_value_in), .rpt_ready_in(rpt_ready_in),
  .rpt_valid_out(rpt_valid_out), .rpt_is_level_out(rpt_is_level_out),
  .rpt_addr_out(rpt_addr_out), .rpt_data_out(rpt_data_out),
  .drive_addr_out(drive_addr_out), .drive_level_out(drive_level_out),
  .drive_valid_out(drive_valid_out), .slave_out(slave_out));

// file: dv/lls_rpt_sink.sv
`timescale 1ns/100ps
// ----------------------------------------
// Report receiver, prompt or slow
// ----------------------------------------
module lls_rpt_sink (
  input wire clk_in,
  input wire resetn_in,
  input wire slow_in,
  output wire ready_out
);
  reg [1:0] cnt_r;
  always @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  assign ready_out = !slow_in || (cnt_r == 2'h3);
endmodule // lls_rpt_sink

// file: dv/tb_lls_lamp_ctrl.sv
`timescale 1ns/100ps
`include "lls_defs.vh"
module tb_lls_lamp_ctrl;
  logic clk_in, resetn_in, burn, slow, vb, rdy, rpt_valid_out, rpt_is_level_out;
  logic drive_valid_out;
  logic [1:0] clr, sw_mode, lv_mode;
  logic [7:0] mn, mx, v8, vld, rpt_data_out, drive_level_out, tot, sw29, lv29;
  logic [6:0] lamp;
  logic [5:0] rpt_addr_out, drive_addr_out;
  logic [63:0] slave_out;
  logic [7:0] sw_cnt [64];
  logic [7:0] lv_cnt [64];
  int bad_count, checks_done, cyc;
  lls_lamp_ctrl #(.SCAN_GAP(2)) i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .download_in(clr[0]), .supply_return_in(clr[1]), .min_level_in(mn), .max_level_in(mx),
    .burn_in_in(burn), .switch_rpt_mode_in(sw_mode), .level_rpt_mode_in(lv_mode),
    .select_valid_in(vld[5]), .select_lamp_in(lamp), .sel_slave_valid_in(vld[6]),
    .sel_slave_value_in(vb), .chan_slave_valid_in(vld[7]), .chan_slave_value_in(vb),
    .lamp_num_in(lamp), .set_level_valid_in(vld[0]), .set_level_in(v8),
    .switch_valid_in(vld[1]), .switch_value_in(vb), .dim_valid_in(vld[2]), .dim_up_in(vb),
    .chan_switch_valid_in(vld[3]), .chan_switch_value_in(vb), .chan_dim_valid_in(vld[4]),
    .chan_dim_up_in(vb), .rpt_ready_in(rdy), .rpt_valid_out(rpt_valid_out),
    .rpt_is_level_out(rpt_is_level_out), .rpt_addr_out(rpt_addr_out),
    .rpt_data_out(rpt_data_out), .drive_addr_out(drive_addr_out),
    .drive_level_out(drive_level_out), .drive_valid_out(drive_valid_out),
    .slave_out(slave_out));
  lls_rpt_sink i_sink (.clk_in(clk_in), .resetn_in(resetn_in), .slow_in(slow),
    .ready_out(rdy));
  initial
  begin
    clk_in = 0;
    forever #50 clk_in = ~clk_in;
  end
  // ----------------------------------------
  // Report capture and time limit
  // ----------------------------------------
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      stop_test;
    end
    if (rpt_valid_out === 1'b1 && rdy === 1'b1)
    begin
      tot++;
      if (rpt_is_level_out) lv_cnt[rpt_addr_out]++;
      else sw_cnt[rpt_addr_out]++;
      if (rpt_addr_out == 6'h1D && rpt_is_level_out) lv29 = rpt_data_out;
      if (rpt_addr_out == 6'h1D && !rpt_is_level_out) sw29 = {7'h00, rpt_data_out[0]};
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task stop_test;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task chk64(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t slave bits %h expected %h", $time, g, e);
    end
  endtask
  // Kinds: set, switch, dim, chan switch, chan dim, select, sel slave, chan slave
  task tel(input int k, input logic [6:0] n, input logic [7:0] v);
    @(posedge clk_in) #1;
    lamp = n;
    v8 = v;
    vb = v[0];
    vld = 8'h01 << k;
    @(posedge clk_in) #1;
    vld = 8'h00;
  endtask
  task chk_lvl(input logic [6:0] n, input logic [7:0] e);
    int i;
    repeat (2) @(negedge clk_in);
    for (i = 0; i < 3000 && !(drive_valid_out === 1'b1 && drive_addr_out == n - 1); i++)
      @(negedge clk_in);
    if (i == 3000)
    begin
      bad_count++;
      $display("[FAIL] %0t poll of lamp %0d not seen", $time, n);
    end
    chk8(drive_level_out, e);
  endtask
  task pulse_clr(input logic [1:0] m);
    @(posedge clk_in) #1;
    clr = m;
    repeat (2) @(posedge clk_in) #1;
    clr = 2'h0;
    repeat (6) @(negedge clk_in);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_quiet;
    tel(0, 5, 8'h80);
    chk_lvl(5, 8'h80);
    tel(0, 6, 8'hFF);
    chk_lvl(6, 8'hFF);
    chk8(tot, 8'h00);
  endtask
  task t_lim;
    @(posedge clk_in) #1;
    mn = 8'h40;
    mx = 8'hC0;
    tel(3, 0, 1);
    tel(0, 1, 8'h10);
    chk_lvl(1, 8'h40);
    tel(0, 2, 8'hF0);
    chk_lvl(2, 8'hC0);
    tel(2, 2, 1);
    chk_lvl(2, 8'hC0);
    chk_lvl(10, 8'hC0);
    @(posedge clk_in) #1;
    mn = 8'hD0;
    mx = 8'h30;
    tel(3, 0, 1);
    chk_lvl(10, 8'hD0);
    tel(0, 1, 8'h10);
    chk_lvl(1, 8'h30);
    tel(0, 2, 8'hF0);
    chk_lvl(2, 8'hD0);
    repeat (1100) @(negedge clk_in);
    @(posedge clk_in) #1;
    mn = 8'h40;
    mx = 8'hC0;
  endtask
  task t_burn;
    burn = 1;
    tel(3, 0, 1);
    chk_lvl(4, 8'hFF);
    tel(3, 0, 0);
    chk_lvl(4, 8'h00);
    @(posedge clk_in) #1;
    burn = 0;
    tel(3, 0, 1);
  endtask
  task t_slave;
    tel(0, 12, 8'h70);
    tel(1, 12, 0);
    chk_lvl(12, 8'h00);
    tel(5, 12, 0);
    tel(6, 12, 1);
    chk64(slave_out, 64'h800);
    chk_lvl(12, 8'h70);
    tel(1, 12, 1);
    tel(2, 12, 0);
    chk_lvl(12, 8'h70);
    tel(4, 0, 1);
    chk_lvl(12, 8'h71);
    tel(3, 0, 0);
    chk_lvl(12, 8'h00);
    tel(0, 12, 8'h90);
    chk_lvl(12, 8'h90);
    tel(6, 12, 0);
    chk64(slave_out, 64'h0);
    chk_lvl(12, 8'h90);
    tel(1, 12, 0);
    chk_lvl(12, 8'h00);
    tel(7, 0, 1);
    tel(7, 0, 0);
    chk64(slave_out, ~64'h0);
    tel(5, 20, 0);
    tel(6, 20, 0);
    chk64(slave_out, ~(64'h1 << 19));
    pulse_clr(2'h1);
    chk64(slave_out, 64'h0);
    tel(7, 0, 1);
    pulse_clr(2'h2);
    chk64(slave_out, 64'h0);
  endtask
  task t_rpt;
    logic [7:0] n0;
    @(posedge clk_in) #1;
    slow = 1;
    sw_mode = `LLS_RPT_CHANGE;
    lv_mode = `LLS_RPT_CHANGE;
    tel(1, 30, 1);
    chk_lvl(30, 8'hC0);
    repeat (30) @(negedge clk_in);
    chk8(sw_cnt[29], 8'h01);
    chk8(sw29, 8'h01);
    chk8(lv_cnt[29], 8'h01);
    tel(1, 30, 1);
    chk_lvl(30, 8'hC0);
    repeat (30) @(negedge clk_in);
    chk8(sw_cnt[29], 8'h01);
    n0 = lv_cnt[29];
    chk_lvl(30, 8'hC0);
    repeat (30) @(negedge clk_in);
    chk8(lv_cnt[29], n0);
    @(posedge clk_in) #1;
    sw_mode = `LLS_RPT_ALWAYS;
    lv_mode = `LLS_RPT_ALWAYS;
    tel(0, 30, 8'hC0);
    chk_lvl(30, 8'hC0);
    repeat (30) @(negedge clk_in);
    chk8(lv_cnt[29], n0 + 8'h01);
    chk8(lv29, 8'hC0);
    n0 = sw_cnt[29];
    tel(1, 30, 1);
    chk_lvl(30, 8'hC0);
    repeat (30) @(negedge clk_in);
    chk8(sw_cnt[29], n0 + 8'h01);
  endtask
  initial
  begin
    {resetn_in, burn, slow, vb, clr, sw_mode, lv_mode, mn, v8, vld, lamp, tot} = 0;
    {sw29, lv29} = 0;
    mx = 8'hFF;
    foreach (sw_cnt[i]) sw_cnt[i] = 8'h00;
    foreach (lv_cnt[i]) lv_cnt[i] = 8'h00;
    repeat (8) @(posedge clk_in);
    #1 resetn_in = 1;
    t_quiet;
    t_lim;
    t_burn;
    t_slave;
    t_rpt;
    stop_test;
  end
endmodule // tb_lls_lamp_ctrl

// file: hw/lls_clamp.v
`timescale 1ns/100ps
`include "lls_defs.vh"
// ----------------------------------------
// Level limiter
// ----------------------------------------
module lls_clamp (
  input wire [7:0] level_in,
  input wire [7:0] min_in,
  input wire [7:0] max_in,
  input wire burn_in_in,
  output reg [7:0] level_out
);
  reg [7:0] lo_eff;
  reg [7:0] hi_eff;
  always @*
  begin
    lo_eff = (min_in > max_in) ? max_in : min_in;
    hi_eff = (max_in < min_in) ? min_in : max_in;
    if (burn_in_in)
    begin
      level_out = (level_in == `LLS_LEVEL_OFF) ? `LLS_LEVEL_OFF : `LLS_LEVEL_FULL;
    end
    else if (level_in == `LLS_LEVEL_OFF)
    begin
      level_out = `LLS_LEVEL_OFF;
    end
    else if (level_in < lo_eff)
    begin
      level_out = lo_eff;
    end
    else if (level_in > hi_eff)
    begin
      level_out = hi_eff;
    end
    else
    begin
      level_out = level_in;
    end
  end
endmodule // lls_clamp

// file: hw/lls_defs.vh
`ifndef LLS_DEFS_VH
`define LLS_DEFS_VH
// ----------------------------------------
// Levels and policies
// ----------------------------------------
`define LLS_LEVEL_OFF 8'h00
`define LLS_LEVEL_FULL 8'hFF
`define LLS_RPT_NONE 2'h0
`define LLS_RPT_CHANGE 2'h1
`define LLS_RPT_ALWAYS 2'h2
`define LLS_LAMPS 64
`define LLS_ADDR_W 6
// ----------------------------------------
// Dimming and scan timing
// ----------------------------------------
`define LLS_DIM_STEP 8'h01
`define LLS_SCAN_GAP_US 100
`define LLS_CLK_MHZ 10
`define LLS_SCAN_GAP_CYC (`LLS_SCAN_GAP_US * `LLS_CLK_MHZ)
`endif

// file: hw/lls_lamp_ctrl.v
`timescale 1ns/100ps
`include "lls_defs.vh"
// Contract
// - Below lower limit applies the lower limit
// - Above upper limit applies the upper limit
// - Lower above upper: lower becomes upper
// - Upper below lower: upper becomes lower
// - Burn-in drives only full off or on
// - Limits hold for central, dimming, direct
// - Default sends no switch or level reports
// - Switch report on flip or every telegram
// - Level report on scan change or telegram
// - Lamps polled in turn, reports may lag
// - Select lamp, then write slave bit
// - Slave entry applies last level received
// - Slave discards individual switch and dimming
// - Channel broadcasts still act on slaves
// - Slave exit keeps level, reopens objects
// - Download or supply return clears slave
// - Channel slave telegram sets all slaves
// - Clearing one slave leaves others unchanged
// - Lamp number minus one is address
module lls_lamp_ctrl #(
  parameter LAMPS = `LLS_LAMPS,
  parameter AW = `LLS_ADDR_W,
  parameter SCAN_GAP = `LLS_SCAN_GAP_CYC
) (
  input wire clk_in,
  input wire resetn_in,
  input wire download_in,
  input wire supply_return_in,
  input wire [7:0] min_level_in,
  input wire [7:0] max_level_in,
  input wire burn_in_in,
  input wire [1:0] switch_rpt_mode_in,
  input wire [1:0] level_rpt_mode_in,
  input wire select_valid_in,
  input wire [6:0] select_lamp_in,
  input wire sel_slave_valid_in,
  input wire sel_slave_value_in,
  input wire chan_slave_valid_in,
  input wire chan_slave_value_in,
  input wire [6:0] lamp_num_in,
  input wire set_level_valid_in,
  input wire [7:0] set_level_in,
  input wire switch_valid_in,
  input wire switch_value_in,
  input wire dim_valid_in,
  input wire dim_up_in,
  input wire chan_switch_valid_in,
  input wire chan_switch_value_in,
  input wire chan_dim_valid_in,
  input wire chan_dim_up_in,
  input wire rpt_ready_in,
  output reg rpt_valid_out,
  output reg rpt_is_level_out,
  output reg [AW-1:0] rpt_addr_out,
  output reg [7:0] rpt_data_out,
  output reg [AW-1:0] drive_addr_out,
  output reg [7:0] drive_level_out,
  output reg drive_valid_out,
  output wire [LAMPS-1:0] slave_out
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg dl_s1_r, dl_s2_r, sr_s1_r, sr_s2_r;
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dl_s1_r <= 1'b0;
      dl_s2_r <= 1'b0;
      sr_s1_r <= 1'b0;
      sr_s2_r <= 1'b0;
    end
    else
    begin
      dl_s1_r <= download_in;
      dl_s2_r <= dl_s1_r;
      sr_s1_r <= supply_return_in;
      sr_s2_r <= sr_s1_r;
    end
  end
  // ----------------------------------------
  // Slave clear request
  // ----------------------------------------
  wire clear_all = dl_s2_r | sr_s2_r;
  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  wire [AW-1:0] tel_addr = lamp_num_in[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
  // ----------------------------------------
  // Selected lamp
  // ----------------------------------------
  reg [AW-1:0] sel_addr_r;
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sel_addr_r <= {AW{1'b0}};
    else if (select_valid_in)
      sel_addr_r <= select_lamp_in[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
  end
  // ----------------------------------------
  // Per-lamp state
  // ----------------------------------------
  reg [7:0] level_r [0:LAMPS-1];
  reg [7:0] last_set_r [0:LAMPS-1];
  reg [7:0] reported_r [0:LAMPS-1];
  reg [LAMPS-1:0] slave_r;
  reg [LAMPS-1:0] sw_pend_r;
  reg [LAMPS-1:0] lv_pend_r;
  assign slave_out = slave_r;
  // ----------------------------------------
  // Telegram level sources
  // ----------------------------------------
  wire [7:0] dim_src = level_r[tel_addr];
  wire [7:0] dim_req = dim_up_in ?
    ((dim_src == `LLS_LEVEL_FULL) ? dim_src : dim_src + `LLS_DIM_STEP) :
    ((dim_src == `LLS_LEVEL_OFF) ? dim_src : dim_src - `LLS_DIM_STEP);
  wire [7:0] sel_src = last_set_r[sel_addr_r];
  wire [7:0] tel_lim, dim_lim, sel_lim;
  lls_clamp u_tel (
    .level_in(set_level_in), .min_in(min_level_in), .max_in(max_level_in),
    .burn_in_in(burn_in_in), .level_out(tel_lim)
  );
  lls_clamp u_dim (
    .level_in(dim_req), .min_in(min_level_in), .max_in(max_level_in),
    .burn_in_in(burn_in_in), .level_out(dim_lim)
  );
  lls_clamp u_sel (
    .level_in(sel_src), .min_in(min_level_in), .max_in(max_level_in),
    .burn_in_in(burn_in_in), .level_out(sel_lim)
  );
  // ----------------------------------------
  // Switch-on level
  // ----------------------------------------
  wire [7:0] on_lim = burn_in_in ? `LLS_LEVEL_FULL :
    ((max_level_in < min_level_in) ? min_level_in : max_level_in);
  wire tel_blocked = slave_r[tel_addr];
  // ----------------------------------------
  // Per-lamp next state
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < LAMPS; g = g + 1)
    begin : g_lamp
      wire [7:0] cur = level_r[g];
      wire [7:0] cdim = chan_dim_up_in ?
        ((cur == `LLS_LEVEL_FULL) ? cur : cur + `LLS_DIM_STEP) :
        ((cur == `LLS_LEVEL_OFF) ? cur : cur - `LLS_DIM_STEP);
      wire [7:0] cdim_lim;
      lls_clamp u_cdim (
        .level_in(cdim), .min_in(min_level_in), .max_in(max_level_in),
        .burn_in_in(burn_in_in), .level_out(cdim_lim)
      );
      wire is_tel = (tel_addr == g);
      wire is_sel = (sel_addr_r == g);
      wire sel_on = sel_slave_valid_in & is_sel & sel_slave_value_in;
      wire ind_ok = ~tel_blocked;
      reg [7:0] lvl_nxt;
      reg slave_nxt;
      reg touched;
      always @*
      begin
        lvl_nxt = cur;
        touched = 1'b0;
        slave_nxt = slave_r[g];
        if (clear_all)
          slave_nxt = 1'b0;
        else if (chan_slave_valid_in && chan_slave_value_in)
          slave_nxt = 1'b1;
        else if (sel_slave_valid_in && is_sel)
          slave_nxt = sel_slave_value_in;
        if (chan_switch_valid_in)
        begin
          lvl_nxt = chan_switch_value_in ? on_lim : `LLS_LEVEL_OFF;
          touched = 1'b1;
        end
        else if (chan_dim_valid_in)
        begin
          lvl_nxt = cdim_lim;
          touched = 1'b1;
        end
        else if (sel_on && !slave_r[g] && !clear_all)
        begin
          lvl_nxt = sel_lim;
          touched = 1'b1;
        end
        else if (set_level_valid_in && is_tel)
        begin
          lvl_nxt = tel_lim;
          touched = 1'b1;
        end
        else if (switch_valid_in && is_tel && ind_ok)
        begin
          lvl_nxt = switch_value_in ? on_lim : `LLS_LEVEL_OFF;
          touched = 1'b1;
        end
        else if (dim_valid_in && is_tel && ind_ok)
        begin
          lvl_nxt = dim_lim;
          touched = 1'b1;
        end
      end
      // ----------------------------------------
      // Lamp registers and pending flags
      // ----------------------------------------
      always @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          level_r[g] <= `LLS_LEVEL_OFF;
          last_set_r[g] <= `LLS_LEVEL_OFF;
          slave_r[g] <= 1'b0;
          sw_pend_r[g] <= 1'b0;
        end
        else
        begin
          level_r[g] <= lvl_nxt;
          slave_r[g] <= slave_nxt;
          if (set_level_valid_in && is_tel)
            last_set_r[g] <= set_level_in;
          if (touched && switch_rpt_mode_in == `LLS_RPT_ALWAYS)
            sw_pend_r[g] <= 1'b1;
          else if (rpt_valid_out && rpt_ready_in && !rpt_is_level_out && rpt_addr_out == g)
            sw_pend_r[g] <= 1'b0;
        end
      end
      always @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          lv_pend_r[g] <= 1'b0;
        else if (touched && level_rpt_mode_in == `LLS_RPT_ALWAYS)
          lv_pend_r[g] <= 1'b1;
        else if (rpt_valid_out && rpt_ready_in && rpt_is_level_out && rpt_addr_out == g)
          lv_pend_r[g] <= 1'b0;
      end
    end
  endgenerate
  // ----------------------------------------
  // Cyclic scan and reporting
  // ----------------------------------------
  localparam ST_GAP = 2'h0;
  localparam ST_POLL = 2'h1;
  localparam ST_SEND = 2'h2;
  reg [1:0] state_r;
  reg [AW-1:0] scan_r;
  reg [15:0] gap_r;
  reg [7:0] scan_lvl_r;
  reg send_lvl_r;
  reg send_sw_r;
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r <= ST_GAP;
      scan_r <= {AW{1'b0}};
      gap_r <= 16'h0000;
      scan_lvl_r <= 8'h00;
      send_lvl_r <= 1'b0;
      send_sw_r <= 1'b0;
      rpt_valid_out <= 1'b0;
      rpt_is_level_out <= 1'b0;
      rpt_addr_out <= {AW{1'b0}};
      rpt_data_out <= 8'h00;
      drive_valid_out <= 1'b0;
      drive_addr_out <= {AW{1'b0}};
      drive_level_out <= 8'h00;
    end
    else
    begin
      drive_valid_out <= 1'b0;
      case (state_r)
        ST_GAP:
        begin
          if (gap_r == SCAN_GAP[15:0])
          begin
            gap_r <= 16'h0000;
            state_r <= ST_POLL;
          end
          else
            gap_r <= gap_r + 16'h0001;
        end
        ST_POLL:
        begin
          scan_lvl_r <= level_r[scan_r];
          drive_valid_out <= 1'b1;
          drive_addr_out <= scan_r;
          drive_level_out <= level_r[scan_r];
          send_lvl_r <= lv_pend_r[scan_r] |
            ((level_rpt_mode_in == `LLS_RPT_CHANGE) &&
             (level_r[scan_r] != reported_r[scan_r]));
          send_sw_r <= sw_pend_r[scan_r] |
            ((switch_rpt_mode_in == `LLS_RPT_CHANGE) &&
             ((level_r[scan_r] == 8'h00) != (reported_r[scan_r] == 8'h00)));
          state_r <= ST_SEND;
        end
        ST_SEND:
        begin
          if (rpt_valid_out)
          begin
            if (rpt_ready_in)
              rpt_valid_out <= 1'b0;
          end
          else if (send_sw_r)
          begin
            send_sw_r <= 1'b0;
            rpt_valid_out <= 1'b1;
            rpt_is_level_out <= 1'b0;
            rpt_addr_out <= scan_r;
            rpt_data_out <= {7'h00, scan_lvl_r != 8'h00};
          end
          else if (send_lvl_r)
          begin
            send_lvl_r <= 1'b0;
            rpt_valid_out <= 1'b1;
            rpt_is_level_out <= 1'b1;
            rpt_addr_out <= scan_r;
            rpt_data_out <= scan_lvl_r;
          end
          else
          begin
            scan_r <= scan_r + {{(AW-1){1'b0}}, 1'b1};
            state_r <= ST_GAP;
          end
        end
        default:
          state_r <= ST_GAP;
      endcase
    end
  end
  // ----------------------------------------
  // Reported level memory
  // ----------------------------------------
  generate
    for (g = 0; g < LAMPS; g = g + 1)
    begin : g_rep
      always @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          reported_r[g] <= 8'h00;
        else if (state_r == ST_POLL && scan_r == g)
          reported_r[g] <= level_r[g];
      end
    end
  endgenerate
endmodule // lls_lamp_ctrl
